/* logic/cpv_top.sv */
// channel power and volume sequencer: register file, zero-crossing sync, eight channels
// Contract
// - reset low keeps everything powered down and refuses register accesses.
// - reset low returns every control setting to its default.
// - after reset accesses work; amplifiers stay off until global power-down clears.
// - channel powers up only with global and own power-down bits clear.
// - after reset channel bits read clear, global power-down bit reads set.
// - channel volume held at mute throughout its power-up sequence.
// - once powered up the channel takes the level from current settings.
// - own or global power-down bit set sends the channel to power-down.
// - channel is muted before its amplifier starts powering down.
// - power sequence mute and volume changes obey the zero-crossing mode.
// - a setting picks immediate or zero-crossing timed volume changes.
// - eight time-outs from 5 to 50 ms; on expiry apply at once.
// - on a newer command, apply the older at once or discard it.
// - gain spans 118 dB in quarter dB steps, -96 to +22 dB.
// - eight volume and mute controls, each tied to one channel only.
// - three master controls, each over a chosen channel group, one write each.
`timescale 1ns/100ps
`default_nettype none
module cpv_top #(
	parameter int ZC_STEP_CYCLES = cpv_pkg::CPV_ZC_STEP_CYCLES,
	parameter int AMP_WAKE_CYCLES = cpv_pkg::CPV_AMP_WAKE_CYCLES
) (
	input wire logic CLK_IN, // 125 MHz system clock
	input wire logic RST_N_IN, // sync reset, low active
	input wire logic REG_WR_IN, // register write strobe
	input wire logic REG_RD_IN, // register read strobe
	input wire logic [6:0] REG_ADDR_IN, // register address
	input wire logic [7:0] REG_WDATA_IN, // write data
	output logic [7:0] REG_RDATA_OUT, // read data
	output logic REG_ACK_OUT, // access taken, one cycle
	input wire logic [7:0] ZC_IN, // per channel signal polarity
	output logic [71:0] CH_GAIN_OUT, // applied gain codes, 9 bits each
	output logic [7:0] CH_MUTE_OUT, // applied mutes
	output logic [7:0] CH_AMP_ON_OUT // amplifier power enables
);
	typedef struct packed {
		logic [7:0][7:0] vol;
		logic [7:0] qdb;
		logic [7:0] mute;
		logic [7:0] zc_cfg;
		logic global_power_down_bit;
		logic [7:0] pdn;
		logic [2:0][7:0] mvol;
		logic [2:0][7:0] mctl;
		logic [2:0][7:0] mask;
		logic [7:0] rdata;
		logic ack;
		logic [7:0] sy1;
		logic [7:0] sy2;
		logic [7:0] sy3;
		logic [7:0] zc_held;
		logic [7:0] zc_pulse;
		logic [7:0][8:0] gain;
		logic [7:0] mute_o;
		logic [7:0] amp;
	} cpv_top_t;
	cpv_top_t s;
	cpv_top_t next_s;
	logic [7:0][8:0] eff_gain;
	logic [7:0] eff_mute;
	logic [7:0][8:0] seq_gain;
	logic [7:0] seq_mute;
	logic [7:0] seq_amp;
	logic [2:0][8:0] mst_code;
	logic [2:0] mst_mute;

	// hit on one field of a master slot
	function automatic logic mst_hit(input logic [6:0] addr, input int m, input logic [6:0] off);
		logic [6:0] base;
		base = cpv_pkg::CPV_ADDR_MST_BASE + 7'(m * int'(cpv_pkg::CPV_ADDR_MST_STRIDE));
		return addr == base + off;
	endfunction

	// true when the address is one of the individual volume registers
	function automatic logic vol_hit(input logic [6:0] addr);
		return (addr >= cpv_pkg::CPV_ADDR_CH_VOL_FIRST) && (addr <= cpv_pkg::CPV_ADDR_CH_VOL_LAST);
	endfunction

	// master codes and mutes as seen by every channel
	always_comb begin
		for (int m = 0; m < 3; m++) begin
			mst_code[m] = {s.mvol[m], s.mctl[m][cpv_pkg::CPV_MST_QDB_BIT]};
			mst_mute[m] = s.mctl[m][cpv_pkg::CPV_MST_MUTE_BIT];
		end
	end

	// per channel gain combiner and power sequencer
	generate
		for (genvar c = 0; c < 8; c++) begin : g_ch
			cpv_gain_sum u_sum (
				.ind_code_in({s.vol[c], s.qdb[c]}),
				.ind_mute_in(s.mute[c]),
				.mst_code_in(mst_code),
				.mst_mute_in(mst_mute),
				.mst_en_in({s.mask[2][c], s.mask[1][c], s.mask[0][c]}),
				.gain_out(eff_gain[c]),
				.mute_out(eff_mute[c])
			);
			cpv_chan_seq #(
				.WAKE_CYCLES(AMP_WAKE_CYCLES),
				.STEP_CYCLES(ZC_STEP_CYCLES)
			) u_seq (
				.clk_in(CLK_IN),
				.rst_n_in(RST_N_IN),
				.pwr_req_in(!s.global_power_down_bit && !s.pdn[c]),
				.tgt_gain_in(eff_gain[c]),
				.tgt_mute_in(eff_mute[c]),
				.zc_in(s.zc_pulse[c]),
				.zc_wait_in(s.zc_cfg[cpv_pkg::CPV_ZC_WAIT_BIT]),
				.to_sel_in(s.zc_cfg[cpv_pkg::CPV_ZC_SEL_LSB +: 3]),
				.keep_prev_in(s.zc_cfg[cpv_pkg::CPV_ZC_KEEP_BIT]),
				.gain_out(seq_gain[c]),
				.mute_out(seq_mute[c]),
				.amp_on_out(seq_amp[c])
			);
		end
	endgenerate

	// next state: sync, register access, output copies
	always_comb begin
		next_s = s;
		next_s.ack = 1'b0;
		// three stage sync, polarity change counts once stages two and three agree
		next_s.sy1 = ZC_IN;
		next_s.sy2 = s.sy1;
		next_s.sy3 = s.sy2;
		for (int c = 0; c < 8; c++) begin
			next_s.zc_pulse[c] = 1'b0;
			if ((s.sy2[c] == s.sy3[c]) && (s.sy3[c] != s.zc_held[c])) begin
				next_s.zc_held[c] = s.sy3[c];
				next_s.zc_pulse[c] = 1'b1;
			end
		end
		// read returns the value held before any same-cycle write
		if (REG_RD_IN) begin
			next_s.rdata = 8'h00;
			if (vol_hit(REG_ADDR_IN)) begin
				next_s.rdata = s.vol[3'(REG_ADDR_IN - cpv_pkg::CPV_ADDR_CH_VOL_FIRST)];
			end
			unique case (REG_ADDR_IN)
				cpv_pkg::CPV_ADDR_QDB: next_s.rdata = s.qdb;
				cpv_pkg::CPV_ADDR_CH_MUTE: next_s.rdata = s.mute;
				cpv_pkg::CPV_ADDR_ZC_CFG: next_s.rdata = s.zc_cfg;
				cpv_pkg::CPV_ADDR_DEV_PWR: next_s.rdata = {7'h00, s.global_power_down_bit};
				cpv_pkg::CPV_ADDR_CH_PWR: next_s.rdata = s.pdn;
				cpv_pkg::CPV_ADDR_STATUS: next_s.rdata = s.amp;
				default: begin
				end
			endcase
			for (int m = 0; m < 3; m++) begin
				if (mst_hit(REG_ADDR_IN, m, cpv_pkg::CPV_MST_OFF_VOL)) begin
					next_s.rdata = s.mvol[m];
				end
				if (mst_hit(REG_ADDR_IN, m, cpv_pkg::CPV_MST_OFF_CTL)) begin
					next_s.rdata = s.mctl[m];
				end
				if (mst_hit(REG_ADDR_IN, m, cpv_pkg::CPV_MST_OFF_MASK)) begin
					next_s.rdata = s.mask[m];
				end
			end
		end
		// writes; unmapped and status addresses are ignored
		if (REG_WR_IN) begin
			if (vol_hit(REG_ADDR_IN)) begin
				next_s.vol[3'(REG_ADDR_IN - cpv_pkg::CPV_ADDR_CH_VOL_FIRST)] = REG_WDATA_IN;
			end
			unique case (REG_ADDR_IN)
				cpv_pkg::CPV_ADDR_QDB: next_s.qdb = REG_WDATA_IN;
				cpv_pkg::CPV_ADDR_CH_MUTE: next_s.mute = REG_WDATA_IN;
				cpv_pkg::CPV_ADDR_ZC_CFG: next_s.zc_cfg = REG_WDATA_IN;
				cpv_pkg::CPV_ADDR_DEV_PWR: next_s.global_power_down_bit = REG_WDATA_IN[cpv_pkg::CPV_GLOBAL_POWER_DOWN_BIT_BIT];
				cpv_pkg::CPV_ADDR_CH_PWR: next_s.pdn = REG_WDATA_IN;
				default: begin
				end
			endcase
			for (int m = 0; m < 3; m++) begin
				if (mst_hit(REG_ADDR_IN, m, cpv_pkg::CPV_MST_OFF_VOL)) begin
					next_s.mvol[m] = REG_WDATA_IN;
				end
				if (mst_hit(REG_ADDR_IN, m, cpv_pkg::CPV_MST_OFF_CTL)) begin
					next_s.mctl[m] = REG_WDATA_IN;
				end
				if (mst_hit(REG_ADDR_IN, m, cpv_pkg::CPV_MST_OFF_MASK)) begin
					next_s.mask[m] = REG_WDATA_IN;
				end
			end
		end
		if (REG_WR_IN || REG_RD_IN) begin
			next_s.ack = 1'b1;
		end
		// registered copies of the channel outputs
		next_s.gain = seq_gain;
		next_s.mute_o = seq_mute;
		next_s.amp = seq_amp;
	end

	// state register; reset restores all defaults and holds accesses off
	always_ff @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			for (int c = 0; c < 8; c++) begin
				s.vol[c] <= cpv_pkg::CPV_RST_VOL;
				s.gain[c] <= 9'h000;
			end
			for (int m = 0; m < 3; m++) begin
				s.mvol[m] <= cpv_pkg::CPV_RST_VOL;
				s.mctl[m] <= cpv_pkg::CPV_RST_MST_CTL;
				s.mask[m] <= cpv_pkg::CPV_RST_MASK;
			end
			s.qdb <= cpv_pkg::CPV_RST_QDB;
			s.mute <= cpv_pkg::CPV_RST_CH_MUTE;
			s.zc_cfg <= cpv_pkg::CPV_RST_ZC_CFG;
			s.global_power_down_bit <= cpv_pkg::CPV_RST_GLOBAL_POWER_DOWN_BIT;
			s.pdn <= cpv_pkg::CPV_RST_CH_PWR;
			s.rdata <= 8'h00;
			s.ack <= 1'b0;
			s.sy1 <= 8'h00;
			s.sy2 <= 8'h00;
			s.sy3 <= 8'h00;
			s.zc_held <= 8'h00;
			s.zc_pulse <= 8'h00;
			s.mute_o <= 8'hff;
			s.amp <= 8'h00;
		end else begin
			s <= next_s;
		end
	end

	// ports straight from the state register
	assign REG_RDATA_OUT = s.rdata;
	assign REG_ACK_OUT = s.ack;
	assign CH_GAIN_OUT = s.gain;
	assign CH_MUTE_OUT = s.mute_o;
	assign CH_AMP_ON_OUT = s.amp;

	a_reset_refuses: assert property (@(posedge CLK_IN)
		!RST_N_IN |=> (!REG_ACK_OUT && CH_AMP_ON_OUT == 8'h00 && CH_MUTE_OUT == 8'hff))
		else $error("access or power seen in reset");
	a_reset_defaults: assert property (@(posedge CLK_IN)
		!RST_N_IN |=> (s.zc_cfg == cpv_pkg::CPV_RST_ZC_CFG && s.mask[0] == cpv_pkg::CPV_RST_MASK
		&& s.vol[0] == cpv_pkg::CPV_RST_VOL))
		else $error("setting not restored by reset");
	a_power_bits_reset: assert property (@(posedge CLK_IN)
		!RST_N_IN |=> (s.global_power_down_bit && s.pdn == 8'h00))
		else $error("power-down bits wrong after reset");
	a_access_taken: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
		(REG_WR_IN || REG_RD_IN) |=> REG_ACK_OUT)
		else $error("access not acknowledged");
	a_global_holds_off: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
		(s.global_power_down_bit && $past(s.global_power_down_bit) && seq_amp == 8'h00) |=> seq_amp == 8'h00)
		else $error("amplifier woke under global power-down");
endmodule
`default_nettype wire

/* logic/cpv_pkg.sv */
// shared constants and types for the channel power and volume sequencer
package cpv_pkg;
	// register byte offsets of the control port map
	localparam logic [6:0] CPV_ADDR_CH_VOL_FIRST = 7'h01;
	localparam logic [6:0] CPV_ADDR_CH_VOL_LAST = 7'h08;
	localparam logic [6:0] CPV_ADDR_QDB = 7'h09;
	localparam logic [6:0] CPV_ADDR_CH_MUTE = 7'h0a;
	localparam logic [6:0] CPV_ADDR_ZC_CFG = 7'h0b;
	localparam logic [6:0] CPV_ADDR_DEV_PWR = 7'h0c;
	localparam logic [6:0] CPV_ADDR_CH_PWR = 7'h0d;
	localparam logic [6:0] CPV_ADDR_MST_BASE = 7'h0e;
	localparam logic [6:0] CPV_ADDR_MST_STRIDE = 7'h03;
	localparam logic [6:0] CPV_ADDR_STATUS = 7'h17;
	// master slot layout: volume, control, mask
	localparam logic [6:0] CPV_MST_OFF_VOL = 7'h00;
	localparam logic [6:0] CPV_MST_OFF_CTL = 7'h01;
	localparam logic [6:0] CPV_MST_OFF_MASK = 7'h02;
	// field positions
	localparam int CPV_ZC_WAIT_BIT = 0;
	localparam int CPV_ZC_SEL_LSB = 1;
	localparam int CPV_ZC_KEEP_BIT = 4;
	localparam int CPV_GLOBAL_POWER_DOWN_BIT_BIT = 0;
	localparam int CPV_MST_QDB_BIT = 0;
	localparam int CPV_MST_MUTE_BIT = 1;
	// reset values
	localparam logic [7:0] CPV_RST_VOL = 8'hc0;
	localparam logic [7:0] CPV_RST_QDB = 8'h00;
	localparam logic [7:0] CPV_RST_CH_MUTE = 8'h00;
	localparam logic [7:0] CPV_RST_ZC_CFG = 8'h01;
	localparam logic CPV_RST_GLOBAL_POWER_DOWN_BIT = 1'b1;
	localparam logic [7:0] CPV_RST_CH_PWR = 8'h00;
	localparam logic [7:0] CPV_RST_MST_CTL = 8'h00;
	localparam logic [7:0] CPV_RST_MASK = 8'hff;
	// gain code in quarter dB, zero at the bottom of the range
	localparam logic signed [11:0] CPV_QDB_ZERO = 12'sh180;
	localparam logic signed [11:0] CPV_QDB_TOP = 12'sh058;
	// timing
	localparam int CPV_CLK_KHZ = 125000;
	localparam int CPV_ZC_STEP_MS = 5;
	localparam int CPV_ZC_STEP_CYCLES = CPV_ZC_STEP_MS * CPV_CLK_KHZ;
	localparam int CPV_AMP_WAKE_US = 1000;
	localparam int CPV_AMP_WAKE_CYCLES = CPV_AMP_WAKE_US * CPV_CLK_KHZ / 1000;
	// time-out multiples of the 5 ms step: 5..50 ms
	localparam logic [7:0][3:0] CPV_ZC_MULT = {4'ha, 4'h8, 4'h6, 4'h5, 4'h4, 4'h3, 4'h2, 4'h1};
	// per channel sequencer states
	typedef enum logic [3:0] {
		CPV_OFF = 4'h1,
		CPV_WAKE = 4'h2,
		CPV_RUN = 4'h4,
		CPV_DRAIN = 4'h8
	} cpv_chan_state_t;
endpackage

/* logic/cpv_gain_sum.sv */
// effective gain and mute of one channel from its own and master controls
`timescale 1ns/100ps
`default_nettype none
module cpv_gain_sum (
	input wire logic [8:0] ind_code_in, // own volume, quarter dB code
	input wire logic ind_mute_in, // own mute
	input wire logic [2:0][8:0] mst_code_in, // master volumes
	input wire logic [2:0] mst_mute_in, // master mutes
	input wire logic [2:0] mst_en_in, // mask bits of this channel
	output logic [8:0] gain_out, // clamped effective code
	output logic mute_out // effective mute
);
	logic signed [11:0] sum;
	logic signed [11:0] lim;

	// sum signed offsets around 0 dB, then clamp into range
	always_comb begin
		sum = $signed({3'h0, ind_code_in}) - cpv_pkg::CPV_QDB_ZERO;
		mute_out = ind_mute_in;
		for (int m = 0; m < 3; m++) begin
			if (mst_en_in[m]) begin
				sum = sum + ($signed({3'h0, mst_code_in[m]}) - cpv_pkg::CPV_QDB_ZERO);
				mute_out = mute_out | mst_mute_in[m];
			end
		end
		lim = sum;
		if (sum > cpv_pkg::CPV_QDB_TOP) begin
			lim = cpv_pkg::CPV_QDB_TOP;
		end else if (sum < -cpv_pkg::CPV_QDB_ZERO) begin
			lim = -cpv_pkg::CPV_QDB_ZERO;
		end
		gain_out = 9'(lim + cpv_pkg::CPV_QDB_ZERO);
	end
endmodule
`default_nettype wire

/* logic/cpv_chan_seq.sv */
// power sequence and zero-crossing volume update of one channel
`timescale 1ns/100ps
`default_nettype none
module cpv_chan_seq #(
	parameter int WAKE_CYCLES = cpv_pkg::CPV_AMP_WAKE_CYCLES,
	parameter int STEP_CYCLES = cpv_pkg::CPV_ZC_STEP_CYCLES
) (
	input wire logic clk_in, // system clock
	input wire logic rst_n_in, // sync reset, low active
	input wire logic pwr_req_in, // both power-down bits clear
	input wire logic [8:0] tgt_gain_in, // wanted gain code
	input wire logic tgt_mute_in, // wanted mute
	input wire logic zc_in, // zero-crossing pulse
	input wire logic zc_wait_in, // wait for zero-crossing
	input wire logic [2:0] to_sel_in, // time-out select
	input wire logic keep_prev_in, // apply older pending on overrun
	output logic [8:0] gain_out, // applied gain code
	output logic mute_out, // applied mute
	output logic amp_on_out // amplifier powered
);
	typedef struct packed {
		cpv_pkg::cpv_chan_state_t fsm;
		logic [22:0] wcnt;
		logic [22:0] tcnt;
		logic pend;
		logic [8:0] p_gain;
		logic p_mute;
		logic [8:0] a_gain;
		logic a_mute;
	} cpv_chan_t;
	cpv_chan_t s;
	cpv_chan_t next_s;
	logic [22:0] limit;
	logic req_mute;
	logic changed;
	logic expire;

	// time-out length from the select and step size
	assign limit = 23'(STEP_CYCLES * int'(cpv_pkg::CPV_ZC_MULT[to_sel_in]));
	// mute is forced outside the run state
	assign req_mute = (s.fsm != cpv_pkg::CPV_RUN) | tgt_mute_in;
	assign changed = {req_mute, tgt_gain_in} != (s.pend ? {s.p_mute, s.p_gain} : {s.a_mute, s.a_gain});
	assign expire = !zc_wait_in | zc_in | (s.tcnt >= limit - 23'h000001);

	// next state
	always_comb begin
		next_s = s;
		// pending change resolves on crossing or time-out
		if (s.pend) begin
			next_s.tcnt = s.tcnt + 23'h000001;
			if (expire) begin
				next_s.a_gain = s.p_gain;
				next_s.a_mute = s.p_mute;
				next_s.pend = 1'b0;
			end
		end
		if (changed) begin
			if (!zc_wait_in) begin
				next_s.a_gain = tgt_gain_in;
				next_s.a_mute = req_mute;
				next_s.pend = 1'b0;
			end else begin
				if (s.pend && !expire && keep_prev_in) begin
					next_s.a_gain = s.p_gain;
					next_s.a_mute = s.p_mute;
				end
				next_s.p_gain = tgt_gain_in;
				next_s.p_mute = req_mute;
				next_s.pend = 1'b1;
				next_s.tcnt = 23'h000000;
			end
		end
		unique case (s.fsm)
			cpv_pkg::CPV_OFF: begin
				if (pwr_req_in) begin
					next_s.fsm = cpv_pkg::CPV_WAKE;
					next_s.wcnt = 23'h000000;
				end
			end
			cpv_pkg::CPV_WAKE: begin
				next_s.wcnt = s.wcnt + 23'h000001;
				if (!pwr_req_in) begin
					next_s.fsm = cpv_pkg::CPV_DRAIN;
				end else if (s.wcnt >= 23'(WAKE_CYCLES - 1)) begin
					next_s.fsm = cpv_pkg::CPV_RUN;
				end
			end
			cpv_pkg::CPV_RUN: begin
				if (!pwr_req_in) begin
					next_s.fsm = cpv_pkg::CPV_DRAIN;
				end
			end
			cpv_pkg::CPV_DRAIN: begin
				if (pwr_req_in) begin
					next_s.fsm = cpv_pkg::CPV_RUN;
				end else if (s.a_mute && !s.pend) begin
					next_s.fsm = cpv_pkg::CPV_OFF;
				end
			end
			default: begin
				next_s.fsm = cpv_pkg::CPV_OFF;
			end
		endcase
	end

	// state register, channel comes out of reset off and muted
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			s <= '{fsm: cpv_pkg::CPV_OFF, wcnt: 23'h000000, tcnt: 23'h000000, pend: 1'b0,
				p_gain: 9'h000, p_mute: 1'b1, a_gain: 9'h000, a_mute: 1'b1};
		end else begin
			s <= next_s;
		end
	end

	assign gain_out = s.a_gain;
	assign mute_out = s.a_mute;
	assign amp_on_out = (s.fsm != cpv_pkg::CPV_OFF);

	a_wake_gated: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(s.fsm == cpv_pkg::CPV_OFF && !pwr_req_in) |=> s.fsm == cpv_pkg::CPV_OFF)
		else $error("channel woke without power request");
	a_wake_muted: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(s.fsm == cpv_pkg::CPV_WAKE) |-> s.a_mute)
		else $error("channel unmuted during wake");
	a_run_applies: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(s.fsm == cpv_pkg::CPV_RUN && pwr_req_in && !zc_wait_in)
		|=> (s.a_gain == $past(tgt_gain_in) && s.a_mute == $past(tgt_mute_in)))
		else $error("target level not applied in run");
	a_drop_drains: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(s.fsm == cpv_pkg::CPV_RUN && !pwr_req_in) |=> s.fsm == cpv_pkg::CPV_DRAIN)
		else $error("power-down request ignored");
	a_mute_first: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(s.fsm == cpv_pkg::CPV_DRAIN) ##1 (s.fsm == cpv_pkg::CPV_OFF) |-> $past(s.a_mute))
		else $error("amplifier off before mute");
	a_timeout_apply: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(s.pend && zc_wait_in && expire && !changed)
		|=> (!s.pend && s.a_gain == $past(s.p_gain) && s.a_mute == $past(s.p_mute)))
		else $error("pending change not applied on expiry");
	a_keep_prev: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(s.pend && changed && zc_wait_in && !expire && keep_prev_in)
		|=> (s.a_gain == $past(s.p_gain) && s.pend))
		else $error("older pending change not applied");
	a_timer_restart: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(changed && zc_wait_in) |=> (s.tcnt == 23'h000000 && s.pend))
		else $error("time-out counter not restarted");
endmodule
`default_nettype wire

/* testbench/cpv_ctl_model.sv */
// controller model: single register accesses on the strobe port
`timescale 1ns/100ps
`default_nettype none
module cpv_ctl_model (
	input wire logic clk_in, // system clock
	input wire logic ack_in, // access acknowledge
	input wire logic [7:0] rdata_in, // read data
	output logic wr_out, // write strobe
	output logic rd_out, // read strobe
	output logic [6:0] addr_out, // register address
	output logic [7:0] wdata_out // write data
);
	// idle port at time zero
	initial begin
		wr_out = 1'b0;
		rd_out = 1'b0;
		addr_out = 7'h00;
		wdata_out = 8'h00;
	end
	// one-cycle strobe; acknowledge and read data stand for the cycle after the taking edge
	task automatic access(input logic wr, input logic [6:0] a, input logic [7:0] d, output logic [7:0] q,
		output logic ok);
		@(posedge clk_in);
		#1;
		wr_out = wr;
		rd_out = !wr;
		addr_out = a;
		wdata_out = d;
		@(posedge clk_in);
		#1;
		ok = (ack_in === 1'b1); // answer taken while it stands, before the next edge drops it
		q = rdata_in;
		wr_out = 1'b0; // a longer strobe would count as a second access
		rd_out = 1'b0;
		addr_out = ~a; // released lines carry no stale value
		wdata_out = ~d;
	endtask
endmodule
`default_nettype wire

/* testbench/cpv_top_tb.sv */
// self-checking bench of the channel power and volume sequencer
`timescale 1ns/100ps
`default_nettype none
module cpv_top_tb;
	logic clk;
	logic rst_n;
	logic wr, rd, ack;
	logic [6:0] addr;
	logic [7:0] wdata, rdata, zc, mute, amp;
	logic [71:0] gain;
	int num_errors = 0;
	int checks = 0;
	cpv_top #(.ZC_STEP_CYCLES(20), .AMP_WAKE_CYCLES(8)) dut (.CLK_IN(clk), .RST_N_IN(rst_n), .REG_WR_IN(wr),
		.REG_RD_IN(rd), .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata), .REG_RDATA_OUT(rdata), .REG_ACK_OUT(ack),
		.ZC_IN(zc), .CH_GAIN_OUT(gain), .CH_MUTE_OUT(mute), .CH_AMP_ON_OUT(amp));
	cpv_ctl_model ctl (.clk_in(clk), .ack_in(ack), .rdata_in(rdata), .wr_out(wr), .rd_out(rd), .addr_out(addr),
		.wdata_out(wdata));
	// 125 MHz clock
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// compare and count
	task automatic chk(input logic [8:0] got, input logic [8:0] exp);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// one channel output: 0 gain, 1 mute, 2 amplifier
	function automatic logic [8:0] sig(input int k, input int c);
		case (k)
			0: sig = gain[9*c+:9];
			1: sig = {8'h00, mute[c]};
			default: sig = {8'h00, amp[c]};
		endcase
	endfunction
	// wait cycles
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// write that must be acknowledged
	task automatic wr_reg(input logic [6:0] a, input logic [7:0] d);
		logic [7:0] q;
		logic ok;
		ctl.access(1'b1, a, d, q, ok);
		#1;
		chk({8'h00, ok}, 9'h001);
	endtask
	// read against an expected value
	task automatic rd_reg(input logic [6:0] a, input logic [7:0] e);
		logic [7:0] q;
		logic ok;
		ctl.access(1'b0, a, 8'h00, q, ok);
		#1;
		chk({ok, q}, {1'b1, e});
	endtask
	// channel output must reach v after lo to hi cycles
	task automatic wt(input int k, input int c, input logic [8:0] v, input int lo, input int hi);
		int n;
		n = 0;
		while (sig(k, c) !== v && n <= hi) begin
			cyc(1);
			n++;
		end
		chk({8'h00, (n >= lo && n <= hi)}, 9'h001);
	endtask
	// settings loaded while powered down, then immediate power-up
	task automatic t_pwrup();
		chk({1'b0, amp}, 9'h000);
		rd_reg(7'h0d, 8'h00);
		rd_reg(7'h0c, 8'h01);
		rd_reg(7'h0b, 8'h01);
		wr_reg(7'h01, 8'hc4);
		wr_reg(7'h0b, 8'h00);
		cyc(20);
		chk({1'b0, amp}, 9'h000);
		wr_reg(7'h0c, 8'h00);
		wt(2, 0, 9'h001, 0, 4);
		chk(sig(1, 0), 9'h001);
		wt(1, 0, 9'h000, 7, 14);
		chk(sig(0, 0), 9'h188);
		chk(sig(0, 1), 9'h180);
		rd_reg(7'h17, 8'hff);
		$display("test power-up done");
	endtask
	// immediate changes, master group, clamp at the top
	task automatic t_vol();
		wr_reg(7'h02, 8'hb0);
		wt(0, 1, 9'h160, 0, 4);
		chk(sig(0, 0), 9'h188);
		wr_reg(7'h09, 8'h02);
		wt(0, 1, 9'h161, 0, 4);
		wr_reg(7'h0e, 8'hc2);
		wr_reg(7'h0f, 8'h01);
		wt(0, 0, 9'h18d, 0, 4);
		chk(sig(0, 1), 9'h166);
		wr_reg(7'h10, 8'hfe);
		wt(0, 0, 9'h188, 0, 4);
		chk(sig(0, 1), 9'h166);
		wr_reg(7'h10, 8'hff);
		wt(0, 0, 9'h18d, 0, 4);
		wr_reg(7'h01, 8'hff);
		wt(0, 0, 9'h1d8, 0, 4);
		wr_reg(7'h0f, 8'h02);
		wt(1, 1, 9'h001, 0, 4);
		chk({1'b0, mute}, 9'h0ff);
		wr_reg(7'h0f, 8'h00);
		wr_reg(7'h0e, 8'hc0);
		wt(1, 1, 9'h000, 0, 4);
		$display("test volume done");
	endtask
	// zero-crossing waits, time-outs and overrun policy
	task automatic t_zc();
		wr_reg(7'h0b, 8'h01);
		wr_reg(7'h03, 8'ha0);
		cyc(8);
		chk(sig(0, 2), 9'h180);
		zc[2] = 1'b1;
		wt(0, 2, 9'h140, 0, 8);
		wr_reg(7'h03, 8'hb0);
		wt(0, 2, 9'h160, 15, 26);
		wr_reg(7'h0b, 8'h0f);
		wr_reg(7'h03, 8'ha0);
		wt(0, 2, 9'h140, 190, 208);
		wr_reg(7'h0b, 8'h11);
		wr_reg(7'h04, 8'ha0);
		wr_reg(7'h04, 8'h90);
		wt(0, 3, 9'h140, 0, 4);
		wt(0, 3, 9'h120, 12, 26);
		wr_reg(7'h0b, 8'h01);
		wr_reg(7'h04, 8'h80);
		wr_reg(7'h04, 8'h70);
		cyc(8);
		chk(sig(0, 3), 9'h120);
		wt(0, 3, 9'h0e0, 5, 20);
		$display("test zero-crossing done");
	endtask
	// channel and global power-down, mute first
	task automatic t_pdn();
		wr_reg(7'h0b, 8'h00);
		wr_reg(7'h0d, 8'h01);
		wt(1, 0, 9'h001, 0, 4);
		chk(sig(2, 0), 9'h001);
		wt(2, 0, 9'h000, 0, 4);
		chk(sig(2, 1), 9'h001);
		wr_reg(7'h0b, 8'h01);
		wr_reg(7'h0d, 8'h05);
		wt(1, 2, 9'h001, 15, 26);
		wt(2, 2, 9'h000, 0, 4);
		wr_reg(7'h0b, 8'h00);
		wr_reg(7'h0d, 8'h04);
		wt(2, 0, 9'h001, 0, 4);
		chk(sig(2, 2), 9'h000);
		wr_reg(7'h0c, 8'h01);
		wt(1, 1, 9'h001, 0, 4);
		wt(2, 1, 9'h000, 0, 4);
		cyc(4);
		chk({1'b0, amp}, 9'h000);
		$display("test power-down done");
	endtask
	// reset in mid-run: accesses refused, defaults back
	task automatic t_rst();
		logic [7:0] q;
		logic ok;
		wr_reg(7'h0c, 8'h00);
		wr_reg(7'h0b, 8'h0f);
		cyc(4);
		rst_n = 1'b0;
		ctl.access(1'b1, 7'h0d, 8'hff, q, ok);
		#1;
		chk({8'h00, ok}, 9'h000);
		chk({1'b0, amp}, 9'h000);
		chk({1'b0, mute}, 9'h0ff);
		rst_n = 1'b1;
		rd_reg(7'h0b, 8'h01);
		rd_reg(7'h0d, 8'h00);
		rd_reg(7'h0c, 8'h01);
		chk({1'b0, amp}, 9'h000);
		$display("test reset done");
	endtask
	// verdict
	task automatic summarize();
		$display("checks=%0d num_errors=%0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// watchdog at 20000 cycles, over forty times the expected run of about 450 cycles
	initial begin
		#(8 * 20000);
		num_errors++;
		$display("watchdog expired");
		summarize();
	end
	// main sequence
	initial begin
		rst_n = 1'b0;
		zc = 8'h00;
		repeat (2) @(posedge clk);
		#1;
		rst_n = 1'b1;
		t_pwrup();
		t_vol();
		t_zc();
		t_pdn();
		t_rst();
		summarize();
	end
endmodule
`default_nettype wire
